/* File: adc_window_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_WINDOW_CONSTS_SVH
`define ADC_WINDOW_CONSTS_SVH

// Register offsets on the plain register port
`define OFS_REFERENCE_SELECT   6'h02
`define OFS_WINDOW_CONTROL     6'h03
`define OFS_INTERRUPT_ENABLE   6'h04
`define OFS_INTERRUPT_FLAGS    6'h05
`define OFS_CONVERSION_STATUS  6'h06
`define OFS_ACCUMULATION       6'h09

// Reset values
`define RST_REFERENCE          3'h0
`define RST_WINDOW_CONTROL     4'h0
`define RST_INTERRUPT          6'h00
`define RST_ACCUMULATION       4'h0

// Field positions
`define REF_CHOICE_MSB         2
`define REF_INTERNAL_BIT       2
`define WIN_SOURCE_BIT         3
`define WIN_MODE_MSB           2
`define FLAG_MSB               5
`define ACC_CODE_MSB           3

// Flag and enable bit positions, and the busy bit of the status register
`define BIT_TRIGGER_OVERRUN    5
`define BIT_SAMPLE_OVERWRITE   4
`define BIT_RESULT_OVERWRITE   3
`define BIT_WINDOW_MATCH       2
`define BIT_SAMPLE_READY       1
`define BIT_RESULT_READY       0
`define BIT_CONVERTER_BUSY     0

// Window compare mode codes
`define WIN_MODE_NONE          3'h0
`define WIN_MODE_BELOW         3'h1
`define WIN_MODE_ABOVE         3'h2
`define WIN_MODE_INSIDE        3'h3
`define WIN_MODE_OUTSIDE       3'h4

// Largest accumulation code (1024 samples)
`define ACC_CODE_MAX           4'hA

// Internal reference start-up time and clock rate
`define REF_SETTLE_US          60
`define CLK_MHZ                20
`define REF_SETTLE_CYCLES      (`REF_SETTLE_US * `CLK_MHZ)

`endif

/* File: adc_window_pkg.sv */
// Types shared by the converter control block
package adc_window_pkg;

  // Conversion sequencer states
  typedef enum logic [0:0] {
    CONV_IDLE,
    CONV_RUN
  } conv_state_t;

endpackage : adc_window_pkg

/* File: adc_window_irq_status.sv */
// Converter reference, window compare, interrupt and busy control
`include "adc_window_consts.svh"

// Operation
// - A 3-bit reference choice selects supply, external pin or four internal references; codes 1 and 3 are reserved.
// - After switching to an internal reference, conversions wait a 60 us start-up interval.
// - The window source bit picks the low 16 bits of the result (0) or of the latest sample (1).
// - The window mode code selects off, below, above, inside or outside; other codes are reserved.
// - The window compare uses strict less-than and greater-than against the 16-bit thresholds.
// - Six read-write interrupt enables sit at bits 5 down to 0.
// - Each flag shares its enable's bit, clears on a written one and ignores a written zero.
// - A start trigger during a conversion sets the trigger overrun flag.
// - A new sample replacing an unread sample sets the sample overwrite flag.
// - A new result replacing an unread result sets the result overwrite flag.
// - On completion, or on each sample when the sample is the source, the window match flag sets when the source meets the chosen window mode.
// - Sample ready sets on every new sample and clears on a sample read or a written one.
// - Result ready sets on each completed result and clears on a result read or a written one.
// - The busy bit is high while converting or while reference settling is pending.
// - One to 1024 consecutive samples accumulate into the result; the sample holds the latest one.
module adc_window_irq_status #(
  parameter int SAMPLE_W = 16,
  parameter int RESULT_W = 32,
  parameter int CNT_W    = 11,
  parameter int SETTLE_W = 12
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [5:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [7:0]          reg_rdata,
  input  wire logic                start_trigger,
  output logic                     conv_start,
  input  wire logic                sample_done,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  input  wire logic                sample_read_strobe,
  input  wire logic                result_read_strobe,
  input  wire logic [15:0]         window_low_threshold,
  input  wire logic [15:0]         window_high_threshold,
  output logic      [2:0]          reference_choice,
  output logic                     reference_ready,
  output logic      [SAMPLE_W-1:0] sample_value,
  output logic      [RESULT_W-1:0] result_value,
  output logic                     converter_busy,
  output logic                     irq
);

  // Register state
  logic [2:0]          reference_reg;
  logic [3:0]          window_ctrl_reg;
  logic [5:0]          enable_reg;
  logic [5:0]          flags_reg;
  logic [3:0]          acc_code_reg;
  logic [SETTLE_W-1:0] settle_reg;
  adc_window_pkg::conv_state_t state_reg;
  logic                pending_reg;
  logic [RESULT_W-1:0] acc_reg;
  logic [CNT_W-1:0]    acc_cnt_reg;
  logic [CNT_W-1:0]    acc_target_reg;
  logic                sample_unread_reg;
  logic                result_unread_reg;
  logic [SAMPLE_W-1:0] sample_reg;
  logic [RESULT_W-1:0] result_reg;
  logic                conv_start_reg;
  logic [7:0]          rdata_reg;

  // Decoded strobes and helpers
  logic                wr_reference;
  logic                wr_window;
  logic                wr_enable;
  logic                wr_flags;
  logic                wr_acc;
  logic                window_source;
  logic [2:0]          window_compare_mode;
  logic                settling;
  logic                can_start;
  logic                start_now;
  logic                trig_overrun;
  logic                sample_take;
  logic [RESULT_W-1:0] acc_sum;
  logic [CNT_W-1:0]    acc_cnt_inc;
  logic                result_take;
  logic [15:0]         win_value;
  logic                win_eval;
  logic                win_hit;
  logic [5:0]          flag_set;
  logic [5:0]          flag_clr;
  logic [CNT_W-1:0]    acc_target_next;

  // Write decode
  assign wr_reference = reg_write && reg_addr == `OFS_REFERENCE_SELECT;
  assign wr_window    = reg_write && reg_addr == `OFS_WINDOW_CONTROL;
  assign wr_enable    = reg_write && reg_addr == `OFS_INTERRUPT_ENABLE;
  assign wr_flags     = reg_write && reg_addr == `OFS_INTERRUPT_FLAGS;
  assign wr_acc       = reg_write && reg_addr == `OFS_ACCUMULATION;

  // Window field split
  assign window_source       = window_ctrl_reg[`WIN_SOURCE_BIT];
  assign window_compare_mode = window_ctrl_reg[`WIN_MODE_MSB:0];

  // Reserved codes kept as written, no settling
  // reference choice storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reference_reg <= `RST_REFERENCE;
    end else if (wr_reference) begin
      reference_reg <= reg_wdata[`REF_CHOICE_MSB:0];
    end
  end

  // Same internal code again leaves the timer alone
  // A change mid-conversion lets that conversion finish
  // start-up timer on a change to an internal reference
  always_ff @(posedge clk) begin
    if (!nrst) begin
      settle_reg <= '0;
    end else if (wr_reference
                 && reg_wdata[`REF_INTERNAL_BIT]
                 && reg_wdata[`REF_CHOICE_MSB:0] != reference_reg) begin
      settle_reg <= SETTLE_W'(`REF_SETTLE_CYCLES);
    end else if (settle_reg != '0) begin
      settle_reg <= settle_reg - SETTLE_W'(1);
    end
  end

  // Settling also holds back new starts
  assign settling = settle_reg != '0;

  // Upper bits dropped, they read back as zero
  // window source and mode storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      window_ctrl_reg <= `RST_WINDOW_CONTROL;
    end else if (wr_window) begin
      window_ctrl_reg <= reg_wdata[`WIN_SOURCE_BIT:0];
    end
  end

  // Enables only gate the request, never the flags
  // interrupt enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable_reg <= `RST_INTERRUPT;
    end else if (wr_enable) begin
      enable_reg <= reg_wdata[`FLAG_MSB:0];
    end
  end

  // Code change takes effect at the next start
  // Accumulation code, reserved codes act as one sample
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_code_reg <= `RST_ACCUMULATION;
    end else if (wr_acc) begin
      acc_code_reg <= reg_wdata[`ACC_CODE_MSB:0];
    end
  end

  // Count one to 1024, fits the counter width
  // samples per result from the accumulation code
  always_comb begin
    acc_target_next = CNT_W'(1);
    if (acc_code_reg <= `ACC_CODE_MAX) begin
      acc_target_next = CNT_W'(1) << acc_code_reg;
    end
  end

  // Start held off while the reference warms up
  // Trigger handling: settling delays, a running conversion refuses
  assign can_start    = state_reg == adc_window_pkg::CONV_IDLE
                        && !settling;
  assign start_now    = can_start && (start_trigger || pending_reg);
  assign trig_overrun = start_trigger
                        && state_reg == adc_window_pkg::CONV_RUN;

  // Only one held start, later ones fold into it
  // Triggers seen while settling and idle wait here; during a conversion they set the overrun flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending_reg <= 1'b0;
    end else if (start_now) begin
      pending_reg <= 1'b0;
    end else if (start_trigger && settling
                 && state_reg == adc_window_pkg::CONV_IDLE) begin
      pending_reg <= 1'b1;
    end
  end

  // Samples outside a conversion are ignored
  // Sample completion and accumulation arithmetic
  assign sample_take = sample_done
                       && state_reg == adc_window_pkg::CONV_RUN;
  assign acc_sum     = acc_reg + RESULT_W'(sample_data);
  assign acc_cnt_inc = acc_cnt_reg + CNT_W'(1);
  assign result_take = sample_take && acc_cnt_inc == acc_target_reg;

  // Run ends on the last sample of the batch
  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= adc_window_pkg::CONV_IDLE;
    end else begin
      unique case (state_reg)
        adc_window_pkg::CONV_IDLE: begin
          if (start_now) begin
            state_reg <= adc_window_pkg::CONV_RUN;
          end
        end
        adc_window_pkg::CONV_RUN: begin
          if (result_take) begin
            state_reg <= adc_window_pkg::CONV_IDLE;
          end
        end
      endcase
    end
  end

  // One sample in flight at a time
  // Start pulse to the core, repeated per accumulated sample
  always_ff @(posedge clk) begin
    if (!nrst) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= start_now || (sample_take && !result_take);
    end
  end

  // Cleared on start so stale sums never leak
  // accumulator and sample count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_reg        <= '0;
      acc_cnt_reg    <= '0;
      acc_target_reg <= CNT_W'(1);
    end else if (start_now) begin
      acc_reg        <= '0;
      acc_cnt_reg    <= '0;
      acc_target_reg <= acc_target_next;
    end else if (sample_take) begin
      acc_reg     <= result_take ? '0 : acc_sum;
      acc_cnt_reg <= result_take ? '0 : acc_cnt_inc;
    end
  end

  // Result holds the full sum, sample the last one
  // latest sample and finished result
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sample_reg <= '0;
      result_reg <= '0;
    end else begin
      if (sample_take) begin
        sample_reg <= sample_data;
      end
      if (result_take) begin
        result_reg <= acc_sum;
      end
    end
  end

  // Feeds the overwrite flags below
  // Unread tracking, a new value wins over a same-cycle read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sample_unread_reg <= 1'b0;
      result_unread_reg <= 1'b0;
    end else begin
      sample_unread_reg <= sample_take
                           || (sample_unread_reg && !sample_read_strobe);
      result_unread_reg <= result_take
                           || (result_unread_reg && !result_read_strobe);
    end
  end

  // Result compare sees the new sum, not the old one
  // window source select
  assign win_value = window_source ? sample_data[15:0] : acc_sum[15:0];
  assign win_eval  = window_source ? sample_take : result_take;

  // Reserved modes never match
  // window mode decode
  always_comb begin
    win_hit = 1'b0;
    case (window_compare_mode)
      `WIN_MODE_BELOW:
        win_hit = win_value < window_low_threshold;
      `WIN_MODE_ABOVE:
        win_hit = win_value > window_high_threshold;
      `WIN_MODE_INSIDE:
        win_hit = win_value > window_low_threshold
                  && win_value < window_high_threshold;
      `WIN_MODE_OUTSIDE:
        win_hit = win_value < window_low_threshold
                  || win_value > window_high_threshold;
      default:
        win_hit = 1'b0;
    endcase
  end

  // One event line per flag bit
  // Flag set sources
  always_comb begin
    flag_set = '0;
    flag_set[`BIT_TRIGGER_OVERRUN]  = trig_overrun;
    flag_set[`BIT_SAMPLE_OVERWRITE] = sample_take && sample_unread_reg;
    flag_set[`BIT_RESULT_OVERWRITE] = result_take && result_unread_reg;
    flag_set[`BIT_WINDOW_MATCH]     = win_eval && win_hit;
    flag_set[`BIT_SAMPLE_READY]     = sample_take;
    flag_set[`BIT_RESULT_READY]     = result_take;
  end

  // Zeros written leave flags alone
  // write-one clear, plus read clears for the ready flags
  always_comb begin
    flag_clr = wr_flags ? reg_wdata[`FLAG_MSB:0] : '0;
    flag_clr[`BIT_SAMPLE_READY] = flag_clr[`BIT_SAMPLE_READY]
                                  || sample_read_strobe;
    flag_clr[`BIT_RESULT_READY] = flag_clr[`BIT_RESULT_READY]
                                  || result_read_strobe;
  end

  // An event in the clear cycle is kept
  // sticky flags, set beats clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_reg <= `RST_INTERRUPT;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // Zero outside the answer cycle eases bus merging
  // Register read, data valid only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (!reg_read) begin
      rdata_reg <= 8'h00;
    end else begin
      case (reg_addr)
        `OFS_REFERENCE_SELECT:  rdata_reg <= {5'h00, reference_reg};
        `OFS_WINDOW_CONTROL:    rdata_reg <= {4'h0, window_ctrl_reg};
        `OFS_INTERRUPT_ENABLE:  rdata_reg <= {2'h0, enable_reg};
        `OFS_INTERRUPT_FLAGS:   rdata_reg <= {2'h0, flags_reg};
        `OFS_CONVERSION_STATUS: rdata_reg <= {7'h00, converter_busy};
        `OFS_ACCUMULATION:      rdata_reg <= {4'h0, acc_code_reg};
        default:                rdata_reg <= 8'h00;
      endcase
    end
  end

  // Busy covers start-up so software waits for it
  // busy while converting or settling
  assign converter_busy = state_reg == adc_window_pkg::CONV_RUN
                          || settling;

  // Level request, drops once masked or cleared
  // interrupt request
  assign irq = |(flags_reg & enable_reg);

  // Remaining outputs
  assign reg_rdata        = rdata_reg;
  assign conv_start       = conv_start_reg;
  assign reference_choice = reference_reg;
  assign reference_ready  = !settling;
  assign sample_value     = sample_reg;
  assign result_value     = result_reg;

endmodule : adc_window_irq_status

/* File: adc_window_irq_checker.sv */
// Port-level checker for the converter control block
module adc_window_irq_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [5:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        start_trigger,
  input wire logic        conv_start,
  input wire logic        sample_done,
  input wire logic [15:0] sample_data,
  input wire logic [2:0]  reference_choice,
  input wire logic        reference_ready,
  input wire logic [15:0] sample_value,
  input wire logic        converter_busy
);
  logic [11:0] low_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Length of the current settling stretch
  always_ff @(posedge clk) begin
    if (!nrst || reference_ready) begin
      low_cnt <= 12'h000;
    end else begin
      low_cnt <= low_cnt + 12'h001;
    end
  end

  sequence s_status_read;
    reg_read && reg_addr == 6'h06;
  endsequence
  sequence s_ref_switch;
    reg_write && reg_addr == 6'h02 && reg_wdata[2] &&
      reg_wdata[2:0] != reference_choice;
  endsequence

  property p_status_read;
    s_status_read |=> reg_rdata == {7'h00, $past(converter_busy)};
  endproperty
  property p_idle_start;
    start_trigger && !converter_busy |=> conv_start;
  endproperty
  property p_start_busy;
    conv_start |-> converter_busy;
  endproperty
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  property p_ref_switch;
    s_ref_switch |=> !reference_ready && converter_busy;
  endproperty
  property p_settle_len;
    $rose(reference_ready) |-> low_cnt == 12'h4B0;
  endproperty
  property p_settle_cap;
    low_cnt <= 12'h4B0;
  endproperty
  property p_sample_take;
    sample_done && converter_busy && reference_ready
      |=> sample_value == $past(sample_data);
  endproperty
  property p_ctrl_read;
    reg_read && reg_addr == 6'h03 |=> reg_rdata[7:4] == 4'h0;
  endproperty

  a_status_read: assert property (p_status_read)
    else $error("status read differs from busy");
  a_idle_start: assert property (p_idle_start)
    else $error("idle trigger gave no start");
  a_start_busy: assert property (p_start_busy)
    else $error("start without busy");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  a_ref_switch: assert property (p_ref_switch)
    else $error("internal reference did not settle");
  a_settle_len: assert property (p_settle_len)
    else $error("settling length wrong");
  a_settle_cap: assert property (p_settle_cap)
    else $error("settling too long");
  a_sample_take: assert property (p_sample_take)
    else $error("sample not stored");
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("window control upper bits set");
endmodule : adc_window_irq_checker

bind adc_window_irq_status adc_window_irq_checker adc_window_irq_checker_i (.*);

/* File: adc_window_irq_status_bench.sv */
// Self-checking bench for the converter control block
module adc_window_irq_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, reg_write, reg_read, start_trigger, sample_done;
  logic        sample_read_strobe, result_read_strobe, conv_start, irq;
  logic        reference_ready, converter_busy;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] sample_data, lo_th, hi_th, sample_value;
  logic [31:0] result_value;
  logic [2:0]  reference_choice;
  int          n_errors, checks, low_cycles;
  localparam logic [3:0]  ctl_tab [10] = '{4'h1, 4'h9, 4'h2, 4'hA, 4'h3,
    4'hB, 4'h4, 4'hC, 4'h8, 4'h5};
  localparam logic [15:0] val_tab [10] = '{16'h00FF, 16'h0100, 16'h0800,
    16'h0801, 16'h0101, 16'h0800, 16'h0050, 16'h0400, 16'h0050, 16'h0050};
  localparam logic [9:0]  win_tab = 10'b0001011001;

  adc_window_irq_status adc_window_irq_status_i (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .start_trigger(start_trigger), .conv_start(conv_start),
    .sample_done(sample_done), .sample_data(sample_data),
    .sample_read_strobe(sample_read_strobe),
    .result_read_strobe(result_read_strobe),
    .window_low_threshold(lo_th), .window_high_threshold(hi_th),
    .reference_choice(reference_choice), .reference_ready(reference_ready),
    .sample_value(sample_value), .result_value(result_value),
    .converter_busy(converter_busy), .irq(irq));

  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cycles spent waiting for the reference
  always @(posedge clk) begin
    if (!reference_ready) low_cycles <= low_cycles + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rdc

  task automatic pulse(input logic s, input logic r);
    @(posedge clk);
    sample_read_strobe <= s;
    result_read_strobe <= r;
    @(posedge clk);
    sample_read_strobe <= 1'b0;
    result_read_strobe <= 1'b0;
  endtask : pulse

  task automatic trig;
    @(posedge clk);
    start_trigger <= 1'b1;
    @(posedge clk);
    start_trigger <= 1'b0;
  endtask : trig

  task automatic samp(input logic [15:0] d);
    @(posedge clk);
    sample_done <= 1'b1;
    sample_data <= d;
    @(posedge clk);
    sample_done <= 1'b0;
    sample_data <= ~d;
  endtask : samp

  task automatic conv(input logic [15:0] d);
    trig;
    #1 chk({conv_start, converter_busy}, 2'b11);
    samp(d);
  endtask : conv

  task automatic t_regs;
    for (int a = 2; a < 7; a++) rdc(6'(a), 8'h00);
    wr(6'h02, 8'hFA);
    #1 chk(reference_choice, 3'h2);
    rdc(6'h02, 8'h02);
    wr(6'h03, 8'hFB);
    rdc(6'h03, 8'h0B);
    wr(6'h04, 8'hFF);
    rdc(6'h04, 8'h3F);
    wr(6'h06, 8'hFF);
    rdc(6'h06, 8'h00);
    rdc(6'h3F, 8'h00);
    wr(6'h02, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_flags;
    wr(6'h03, 8'h01);
    conv(16'h0050);
    #1 chk(result_value, 32'h0000_0050);
    rdc(6'h05, 8'h07);
    chk(irq, 1'b1);
    trig;
    trig;
    samp(16'h0900);
    rdc(6'h05, 8'h3F);
    wr(6'h04, 8'h00);
    #1 chk(irq, 1'b0);
    wr(6'h05, 8'h00);
    rdc(6'h05, 8'h3F);
    wr(6'h05, 8'h3C);
    rdc(6'h05, 8'h03);
    wr(6'h04, 8'h02);
    #1 chk(irq, 1'b1);
    pulse(1'b1, 1'b0);
    rdc(6'h05, 8'h01);
    pulse(1'b0, 1'b1);
    rdc(6'h05, 8'h00);
    chk(irq, 1'b0);
    $display("test flags done");
  endtask : t_flags

  task automatic t_modes;
    for (int i = 0; i < 10; i++) begin
      pulse(1'b1, 1'b1);
      wr(6'h05, 8'h3F);
      wr(6'h03, {4'h0, ctl_tab[i]});
      conv(val_tab[i]);
      rdc(6'h05, {5'h00, win_tab[i], 2'b11});
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_accum;
    wr(6'h09, 8'h01);
    wr(6'h03, 8'h02);
    conv(16'h1234);
    #1 chk(conv_start, 1'b1);
    samp(16'h0100);
    #1 chk(result_value, 32'h0000_1334);
    chk(sample_value, 16'h0100);
    rdc(6'h05, 8'h1F);
    wr(6'h09, 8'h00);
    $display("test accum done");
  endtask : t_accum

  task automatic t_settle;
    wr(6'h02, 8'h04);
    #1 chk({converter_busy, reference_ready}, 2'b10);
    rdc(6'h06, 8'h01);
    trig;
    #1 chk(conv_start, 1'b0);
    for (int i = 0; i < 1300 && !reference_ready; i++) @(posedge clk);
    #1 chk(low_cycles, 1200);
    for (int i = 0; i < 4 && !conv_start; i++) @(posedge clk) #1;
    chk(conv_start, 1'b1);
    samp(16'h0200);
    #1 chk(converter_busy, 1'b0);
    wr(6'h02, 8'h00);
    $display("test settle done");
  endtask : t_settle

  task automatic t_reset;
    wr(6'h04, 8'h3F);
    trig;
    wr(6'h02, 8'h05);
    #1 chk(reference_choice, 3'h5);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk({reference_choice, reference_ready}, 4'h1);
    chk({converter_busy, irq, conv_start}, 3'h0);
    chk({sample_value, result_value[15:0]}, 32'h0000_0000);
    rdc(6'h05, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic test_done;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial begin
    repeat (10000) @(posedge clk);
    n_errors++;
    test_done;
  end

  // Main sequence
  initial begin
    {nrst, reg_write, reg_read, start_trigger, sample_done} = 5'h00;
    {sample_read_strobe, result_read_strobe} = 2'b00;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    sample_data = 16'h0000;
    lo_th = 16'h0100;
    hi_th = 16'h0800;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_flags;
    t_modes;
    t_accum;
    t_settle;
    t_reset;
    test_done;
  end
endmodule : adc_window_irq_status_bench
